/* cfel_pkg.sv */
// Package for the cache fill error logger: register offsets, field positions,
// reset values and the interrupt event layout.
// Assumes a 32-bit APB slave interface with word-aligned registers.
package cfel_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_BUS_STAT   = 8'h00;
  localparam logic [7:0] OFF_FILL_ADDR  = 8'h04;
  localparam logic [7:0] OFF_BRIDGE     = 8'h08;
  localparam logic [7:0] OFF_CLEAR      = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR    = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h18;

  // Field positions of the bus interface error status register.
  localparam int BIT_TAG_ADDR  = 3;
  localparam int BIT_TAG_CTL   = 4;
  localparam int BIT_BC_MULTI  = 7;
  localparam int BIT_FILL_ECC  = 8;
  localparam int BIT_FILL_PAR  = 10;
  localparam int BIT_ISTREAM   = 11;
  localparam int BIT_QW_LO     = 12;
  localparam int BIT_PC_MULTI  = 14;

  // Field positions of the fill address and bridge status registers.
  localparam int FA_LO         = 8;
  localparam int FA_HI         = 14;
  localparam int BIT_LOST      = 0;
  localparam int BIT_LOCKED    = 1;

  // Interrupt event indices.
  localparam int EV_FILL       = 0;
  localparam int EV_MULTI      = 1;
  localparam int EV_LOST       = 2;
  localparam int EV_W          = 3;

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EV_W-1:0] RST_EV = 3'h0;

  typedef enum logic [1:0] {
    CFEL_APB_IDLE,
    CFEL_APB_SETUP,
    CFEL_APB_ACCESS
  } cfel_apb_state_t;

endpackage : cfel_pkg

/* cfel_apb_slave.sv */
// APB slave front end: registers the core's address hit and issues a one-cycle
// write strobe. Assumes the core returns read data combinationally.
`timescale 1ns/1ps
`default_nettype none
module cfel_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] core_rdata,
  input  wire logic        core_hit,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);
  import cfel_pkg::*;

  logic access_q;
  logic access_d;

  // A new access phase is detected once; pready answers it in the next cycle.
  always_comb begin
    access_d = psel && penable && !access_q;
  end

  // Registered answer so that every output stems from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_q <= 1'b0;
      pready   <= 1'b0;
      prdata   <= RST_WORD;
      pslverr  <= 1'b0;
      wr_stb   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= RST_WORD;
    end else begin
      access_q <= access_d;
      pready   <= access_d;
      pslverr  <= access_d && !core_hit;
      prdata   <= (access_d && !pwrite && core_hit) ? core_rdata : RST_WORD;
      wr_stb   <= access_d && pwrite && core_hit;
      wr_addr  <= paddr;
      wr_data  <= pwdata;
    end
  end

endmodule : cfel_apb_slave
`default_nettype wire

/* cfel_irq.sv */
// Interrupt block: sticky event status, write-one-to-clear, enable mask.
// Assumes events are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cfel_irq (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [cfel_pkg::EV_W-1:0] ev,
  input  wire logic                     clr_stb,
  input  wire logic                     en_stb,
  input  wire logic [31:0]              wdata,
  output logic [cfel_pkg::EV_W-1:0]     stat_q,
  output logic [cfel_pkg::EV_W-1:0]     en_q,
  output logic                          irq
);
  import cfel_pkg::*;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= RST_EV;
    end else begin
      stat_q <= (stat_q & ~(clr_stb ? wdata[EV_W-1:0] : RST_EV)) | ev;
    end
  end

  // Enable mask written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= RST_EV;
    end else if (en_stb) begin
      en_q <= wdata[EV_W-1:0];
    end
  end

  // Level interrupt, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & en_q);
    end
  end

endmodule : cfel_irq
`default_nettype wire

/* cfel_logger.sv */
// Cache fill error logger top: captures fill parity and ECC errors, the
// failing quadword and fill address, multiple and lost error flags.
// Assumes fill path event inputs are one-cycle pulses synchronous to pclk.
// Limitation: only the first fill error is logged in detail; later ones raise flags.
// Software must clear the status word before the next error can be logged in full.
//
// Overview of operation
// - Data-cache fill parity error sets fill-error bit, instruction bit cleared.
// - Instruction-cache fill parity error sets both fill-error and instruction bits.
// - Fill parity error logs the failing quadword of the hexaword block.
// - Fill error captures failing physical address bits 14 to 8.
// - ECC error on external fill data sets a dedicated status bit.
// - Chipset fatal error or error during tag-error logging sets backup multi-error.
// - Error while address locked sets lost-error bit and flags it fatal.
// - Fill parity error with parity or ECC bit already set sets multi-error.
`timescale 1ns/1ps
`default_nettype none
module cfel_logger (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fill_par_err,
  input  wire logic        fill_ecc_err,
  input  wire logic        fill_istream,
  input  wire logic [1:0]  fill_qw,
  input  wire logic [33:0] fill_paddr,
  input  wire logic        tag_addr_err,
  input  wire logic        tag_ctl_err,
  input  wire logic        chipset_fatal,
  input  wire logic        bridge_err,
  output logic             fatal_err,
  output logic             irq
);
  import cfel_pkg::*;

  // Status flags live in one register each so that every concern has its own process.
  // The word that software reads is put together from them further down.
  logic [31:0]       stat_word;
  logic [1:0]        tag_in;
  logic [1:0]        tag_q;
  logic              bc_multi_q;
  logic              fill_ecc_q;
  logic              fill_par_q;
  logic              istream_q;
  logic [1:0]        qw_q;
  logic              pc_multi_q;
  logic [31:0]       fill_addr_q;
  logic [31:0]       bridge_q;
  logic              wr_stb;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [31:0]       core_rdata;
  logic              core_hit;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_en;
  logic              clr_biu;
  logic              clr_brg;
  logic              fill_first;
  logic              new_err;
  logic              fill_take;
  logic              clr_irq;
  logic              en_irq;

  // Decoding is used for read and for write address checks.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFF_BUS_STAT) || (a == OFF_FILL_ADDR) || (a == OFF_BRIDGE)
        || (a == OFF_CLEAR) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_CLR)
        || (a == OFF_IRQ_EN);
  endfunction : is_mapped

  cfel_apb_slave u_apb (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .core_rdata (core_rdata),
    .core_hit   (core_hit),
    .wr_stb     (wr_stb),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr)
  );

  // Read mux; write-only registers read back as zero.
  always_comb begin
    core_hit = is_mapped(paddr);
    if (paddr == OFF_BUS_STAT) begin
      core_rdata = stat_word;
    end else if (paddr == OFF_FILL_ADDR) begin
      core_rdata = fill_addr_q;
    end else if (paddr == OFF_BRIDGE) begin
      core_rdata = bridge_q;
    end else if (paddr == OFF_IRQ_STAT) begin
      core_rdata = {29'h0000_0000, irq_stat};
    end else if (paddr == OFF_IRQ_EN) begin
      core_rdata = {29'h0000_0000, irq_en};
    end else begin
      core_rdata = RST_WORD;
    end
  end

  // Write decode is shared by all write strobes, so it lives in one place.
  function automatic logic wr_to(input logic stb, input logic [7:0] a,
                                 input logic [7:0] off);
    return stb && (a == off);
  endfunction : wr_to

  // Clear register: bit 0 clears the status and fill address, bit 1 the bridge.
  // The interrupt clear and enable strobes are decoded here as well.
  always_comb begin
    clr_biu = wr_to(wr_stb, wr_addr, OFF_CLEAR) && wr_data[0];
    clr_brg = wr_to(wr_stb, wr_addr, OFF_CLEAR) && wr_data[1];
    clr_irq = wr_to(wr_stb, wr_addr, OFF_IRQ_CLR);
    en_irq  = wr_to(wr_stb, wr_addr, OFF_IRQ_EN);
  end

  // A fill error is first when neither fill parity nor fill ECC is logged.
  // A clear in the same cycle empties the register, so the new error is first again.
  always_comb begin
    fill_first = !fill_par_q && !fill_ecc_q;
    fill_take  = fill_first || clr_biu;
    new_err    = fill_par_err || fill_ecc_err || tag_addr_err || tag_ctl_err;
    tag_in     = {tag_ctl_err, tag_addr_err};
  end

  // Each tag bit is sticky; an event wins over a clear landing in the same cycle.
  // hold until clear
  generate
    for (genvar t = 0; t < 2; t++) begin : g_tag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tag_q[t] <= 1'b0;
        end else if (tag_in[t]) begin
          tag_q[t] <= 1'b1;
        end else if (clr_biu) begin
          tag_q[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // Only tag bits that stood before this cycle make a new error a multiple one.
  // backup multi error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_multi_q <= 1'b0;
    end else if (chipset_fatal || (new_err && !clr_biu && (|tag_q))) begin
      bc_multi_q <= 1'b1;
    end else if (clr_biu) begin
      bc_multi_q <= 1'b0;
    end
  end

  // Set on every ECC error, so a later parity error is seen as a multiple one.
  // fill ECC flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_ecc_q <= 1'b0;
    end else if (fill_ecc_err) begin
      fill_ecc_q <= 1'b1;
    end else if (clr_biu) begin
      fill_ecc_q <= 1'b0;
    end
  end

  // Only the first fill error is logged, so later ones cannot hide its details.
  // data fill flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_par_q <= 1'b0;
    end else if (fill_par_err && fill_take) begin
      fill_par_q <= 1'b1;
    end else if (clr_biu) begin
      fill_par_q <= 1'b0;
    end
  end

  // Written only when a parity error is the first fill error: one for an instruction fill, zero for data.
  // instruction fill flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istream_q <= 1'b0;
    end else if (fill_par_err && fill_take) begin
      istream_q <= fill_istream;
    end else if (clr_biu) begin
      istream_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qw_q <= 2'b00;
    end else if (fill_par_err && fill_take) begin
      qw_q <= fill_qw;
    end else if (clr_biu) begin
      qw_q <= 2'b00;
    end
  end

  // A parity error judged against the flags that stood before it, never itself.
  // primary multi error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_multi_q <= 1'b0;
    end else if (fill_par_err && !fill_take) begin
      pc_multi_q <= 1'b1;
    end else if (clr_biu) begin
      pc_multi_q <= 1'b0;
    end
  end

  // Status word as software sees it; unused bits read as zero.
  always_comb begin
    stat_word                        = RST_WORD;
    stat_word[BIT_TAG_ADDR]          = tag_q[0];
    stat_word[BIT_TAG_CTL]           = tag_q[1];
    stat_word[BIT_BC_MULTI]          = bc_multi_q;
    stat_word[BIT_FILL_ECC]          = fill_ecc_q;
    stat_word[BIT_FILL_PAR]          = fill_par_q;
    stat_word[BIT_ISTREAM]           = istream_q;
    stat_word[BIT_QW_LO+1:BIT_QW_LO] = qw_q;
    stat_word[BIT_PC_MULTI]          = pc_multi_q;
  end

  // Fill address is captured only on the first fill error.
  // Later errors leave the address alone until software clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_addr_q <= RST_WORD;
    end else if ((fill_par_err || fill_ecc_err) && fill_take) begin
      fill_addr_q <= RST_WORD;
      fill_addr_q[FA_HI:FA_LO] <= fill_paddr[FA_HI:FA_LO];
    end else if (clr_biu) begin
      fill_addr_q <= RST_WORD;
    end
  end

  // Bridge status: the first error locks, later ones mark the error lost.
  // The lock has no release but the clear register, so nothing unlocks by itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_q <= RST_WORD;
    end else begin
      bridge_q <= clr_brg ? RST_WORD : bridge_q;
      if (bridge_err) begin
        bridge_q[BIT_LOCKED] <= 1'b1;
      end
      if (bridge_err && bridge_q[BIT_LOCKED] && !clr_brg) begin
        bridge_q[BIT_LOST] <= 1'b1;
      end
    end
  end

  // Registered so the output stems from a flip-flop, at the cost of one cycle of lag.
  // fatal when lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fatal_err <= 1'b0;
    end else begin
      fatal_err <= bridge_q[BIT_LOST] || bc_multi_q;
    end
  end

  // Interrupt events: any fill error, a chipset fatal or fill parity multiple error, a lost error.
  // Each event is a one-cycle pulse; the interrupt block keeps it sticky.
  always_comb begin
    ev = RST_EV;
    ev[EV_FILL]  = fill_par_err || fill_ecc_err;
    ev[EV_MULTI] = chipset_fatal || (fill_par_err && !fill_first);
    ev[EV_LOST]  = bridge_err && bridge_q[BIT_LOCKED];
  end

  // Interrupt status, enable mask and the level output.
  cfel_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .ev      (ev),
    .clr_stb (clr_irq),
    .en_stb  (en_irq),
    .wdata   (wr_data),
    .stat_q  (irq_stat),
    .en_q    (irq_en),
    .irq     (irq)
  );

endmodule : cfel_logger
`default_nettype wire

/* cfel_fill_model.sv */
// Fill path model: raises error pulses with their fill qualifiers.
// Assumes the logger samples each pulse at the next rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module cfel_fill_model (
  input  wire logic        pclk,
  output logic             par_err,
  output logic             ecc_err,
  output logic             taga_err,
  output logic             tagc_err,
  output logic             chip_fatal,
  output logic             brg_err,
  output logic             istream,
  output logic [1:0]       qw,
  output logic [33:0]      paddr
);
  logic [5:0] ev_q = 6'h00;

  // Qualifiers start at zero so the logger never sees an unknown before the first send.
  initial begin
    {istream, qw, paddr} <= 37'h0;
  end

  // Each event wire is a bit of one vector so that a pair of kinds can be sent.
  assign {par_err, ecc_err, taga_err, tagc_err, chip_fatal, brg_err} = ev_q;

  // Sends kind k, then kind k2 in the very next cycle; qualifiers are
  // inverted afterwards so that a stale value is never mistaken for a live one.
  task automatic send(input logic [5:0] k, input logic [5:0] k2, input logic i,
                      input logic [1:0] q, input logic [33:0] a);
    @(posedge pclk);
    ev_q <= k;
    {istream, qw, paddr} <= {i, q, a};
    @(posedge pclk);
    ev_q <= k2;
    @(posedge pclk);
    ev_q <= 6'h00;
    {istream, qw, paddr} <= ~{i, q, a};
  endtask : send
endmodule : cfel_fill_model
`default_nettype wire

/* cfel_logger_assertions.sv */
// Checker for the cache fill error logger: bus timing and error flags.
// Assumes it is bound to the logger top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cfel_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        fill_par_err,
  input  wire logic        fill_ecc_err,
  input  wire logic        fill_istream,
  input  wire logic [1:0]  fill_qw,
  input  wire logic [33:0] fill_paddr,
  input  wire logic        tag_addr_err,
  input  wire logic        tag_ctl_err,
  input  wire logic        chipset_fatal,
  input  wire logic        bridge_err,
  input  wire logic        fatal_err,
  input  wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Two errors on consecutive edges, the second judged against the first.
  sequence s_pair(x, y);
    x ##1 y;
  endsequence

  a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("access did not end after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_slverr_map: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18}))
    else $error("error response does not match the address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside a response");
  a_chip_fatal: assert property (chipset_fatal |-> ##2 fatal_err)
    else $error("chipset fatal error not flagged");
  a_tag_multi: assert property (s_pair(tag_addr_err || tag_ctl_err,
    fill_par_err || fill_ecc_err) |-> ##2 fatal_err)
    else $error("error during tag error logging not flagged");
  a_lost_fatal: assert property (s_pair(bridge_err, bridge_err) |-> ##2 fatal_err)
    else $error("lost error not treated as fatal");
  a_fatal_hold: assert property ($fell(fatal_err) |->
    $past(pready, 2) && $past(pwrite, 2))
    else $error("fatal flag dropped without a software write");
endmodule : cfel_checker

bind cfel_logger cfel_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fill_par_err(fill_par_err),
  .fill_ecc_err(fill_ecc_err), .fill_istream(fill_istream), .fill_qw(fill_qw),
  .fill_paddr(fill_paddr), .tag_addr_err(tag_addr_err), .tag_ctl_err(tag_ctl_err),
  .chipset_fatal(chipset_fatal), .bridge_err(bridge_err), .fatal_err(fatal_err),
  .irq(irq));
`default_nettype wire

/* cache_fill_error_logger_test.sv */
// Testbench for the cache fill error logger: APB register tests around fill events.
// Assumes the fill path model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module cache_fill_error_logger_test;
  import cfel_pkg::*;
  localparam logic [5:0]  PAR = 6'h20, ECC = 6'h10, TGA = 6'h08, TGC = 6'h04;
  localparam logic [5:0]  CHP = 6'h02, BRG = 6'h01;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [33:0] A1 = 34'h0_1234_5A00;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, fatal_err, irq, serr, par, ecc, is, taga, tagc, chip, brg;
  logic [1:0]  qw;
  logic [33:0] pa;
  logic [7:0]  offs [5] = '{OFF_BUS_STAT, OFF_FILL_ADDR, OFF_BRIDGE, OFF_IRQ_STAT, OFF_IRQ_EN};
  int          error_cnt = 0, samples_checked = 0;

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;

  cfel_logger DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fill_par_err(par), .fill_ecc_err(ecc), .fill_istream(is),
    .fill_qw(qw), .fill_paddr(pa), .tag_addr_err(taga), .tag_ctl_err(tagc),
    .chipset_fatal(chip), .bridge_err(brg), .fatal_err(fatal_err), .irq(irq));
  cfel_fill_model fill (.pclk(pclk), .par_err(par), .ecc_err(ecc), .taga_err(taga),
    .tagc_err(tagc), .chip_fatal(chip), .brg_err(brg), .istream(is), .qw(qw), .paddr(pa));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    samples_checked++;
    if ((got & m) !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got & m, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n), 32'h1, ALL);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic ee);
    apb(1'h0, a, 32'h0);
    chk(rdat, e, m);
    chk({31'h0, serr}, {31'h0, ee}, ALL);
  endtask : rd

  task automatic flags(input logic [1:0] e);
    chk({30'h0, fatal_err, irq}, {30'h0, e}, 32'h3);
  endtask : flags

  task automatic clr();
    wr(OFF_CLEAR, 32'h3);
    wr(OFF_IRQ_CLR, 32'h7);
  endtask : clr

  // Main sequence of register tests.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    foreach (offs[i]) rd(offs[i], 32'h0, ALL, 1'h0);
    flags(2'h0);
    wr(OFF_IRQ_EN, 32'h7);
    fill.send(PAR, 6'h0, 1'h0, 2'h2, A1);
    rd(OFF_BUS_STAT, 32'h2400, ALL, 1'h0);
    rd(OFF_FILL_ADDR, 32'h5A00, 32'h7F00, 1'h0);
    fill.send(PAR, 6'h0, 1'h1, 2'h1, ~A1);
    rd(OFF_BUS_STAT, 32'h6400, ALL, 1'h0);
    rd(OFF_FILL_ADDR, 32'h5A00, 32'h7F00, 1'h0);
    rd(OFF_IRQ_STAT, 32'h3, 32'h7, 1'h0);
    flags(2'h1);
    clr();
    rd(OFF_BUS_STAT, 32'h0, ALL, 1'h0);
    flags(2'h0);
    $display("dcache fill test done");
    fill.send(PAR, 6'h0, 1'h1, 2'h3, ~A1);
    rd(OFF_BUS_STAT, 32'h3C00, ALL, 1'h0);
    rd(OFF_FILL_ADDR, 32'h2500, 32'h7F00, 1'h0);
    clr();
    fill.send(ECC, PAR, 1'h0, 2'h0, A1);
    rd(OFF_BUS_STAT, 32'h4100, 32'h4100, 1'h0);
    rd(OFF_FILL_ADDR, 32'h5A00, 32'h7F00, 1'h0);
    clr();
    $display("icache and ecc test done");
    wr(OFF_IRQ_EN, 32'h0);
    fill.send(CHP, 6'h0, 1'h0, 2'h0, A1);
    rd(OFF_BUS_STAT, 32'h80, 32'h80, 1'h0);
    flags(2'h2);
    wr(OFF_IRQ_EN, 32'h2);
    rd(OFF_IRQ_STAT, 32'h2, 32'h2, 1'h0);
    flags(2'h3);
    clr();
    fill.send(TGA, PAR, 1'h0, 2'h0, A1);
    rd(OFF_BUS_STAT, 32'h88, 32'h98, 1'h0);
    clr();
    fill.send(TGC, ECC, 1'h0, 2'h0, A1);
    rd(OFF_BUS_STAT, 32'h90, 32'h98, 1'h0);
    clr();
    fill.send(BRG, BRG, 1'h0, 2'h0, A1);
    rd(OFF_BRIDGE, 32'h3, 32'h3, 1'h0);
    flags(2'h2);
    rd(OFF_IRQ_STAT, 32'h4, 32'h4, 1'h0);
    clr();
    rd(OFF_BRIDGE, 32'h0, 32'h3, 1'h0);
    flags(2'h0);
    wr(8'h40, ALL);
    rd(8'h40, 32'h0, ALL, 1'h1);
    $display("fatal and unmapped test done");
    close_out();
  end

  // The run needs under two thousand cycles, so this only trips on a hang.
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule : cache_fill_error_logger_test
`default_nettype wire
